// ---- src/scc_defs.svh ----
/*
 * constants for the standby and calibration control register:
 * address, reset value and bit positions.
 * assumes a 16-bit register word on a plain address/strobe port.
 */
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define SCC_ADDR_CTRL 8'h39
`define SCC_RESET_CTRL 16'h0000

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCC_BIT_RSVD_TOP 15
`define SCC_BIT_CAL_DOUBLE 13
`define SCC_BIT_ROUTE 8
`define SCC_BIT_DIAG_KEEP 7
`define SCC_BIT_GPO_KEEP 6
`define SCC_BIT_PWR_SWITCH_KEEP 5
`define SCC_BIT_REG_OFF 4
`define SCC_BIT_BIAS_KEEP 3
`define SCC_BIT_BURN_KEEP 1

// writable bits: 15, 13, 8..3, 1; bits 14, 12..9, 2, 0 read as zero
`define SCC_WRITE_MASK 16'ha1fa

`endif

// ---- src/scc_pkg.sv ----
/*
 * types for the standby and calibration control block.
 * assumes scc_defs.svh supplies the numeric constants.
 */
package scc_pkg;
    typedef logic [15:0] scc_word_type;
    typedef logic [7:0] scc_addr_type;
endpackage

// ---- src/scc_standby_cal_ctrl.sv ----
/*
 * standby and calibration control register with its output decoding:
 * analog regulator off, calibration range double, standby indicator
 * routing onto output pin two, diagnostic and oscillator keep-alive.
 * assumes inputs synchronous to ref_clk_i and a master that never
 * overlaps read and write strobes.
 * the oscillator and pin two outputs are registered, so they trail
 * their inputs by one clock; their consumers must tolerate that lag.
 */
`timescale 1ns/1ns
`include "scc_defs.svh"

module scc_standby_cal_ctrl
    import scc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // device state
    input wire logic in_standby_i,
    input wire logic pin_two_output_enable_i,
    input wire logic pin_two_output_value_i,
    input wire logic overunder_err_enabled_i,
    input wire logic internal_clk_selected_i,
    // controls to the analog and clock blocks
    output logic analog_regulator_off_o,
    output logic cal_range_double_o,
    output logic standby_diag_keepalive_o,
    output logic gpo_keepalive_o,
    output logic pwr_switch_keepalive_o,
    output logic bias_keepalive_o,
    output logic burnout_keepalive_o,
    output logic osc_keepalive_o,
    // output pin two
    output logic output_pin_two_o,
    output logic output_pin_two_oe_o
);

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    // the pin asserts reset at once; only its release waits for two edges
    logic rst_sync1_reg;
    logic rst_sync2_reg;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end

    wire logic rst_n = rst_sync2_reg;

    function automatic logic hits_ctrl(input logic [ADDR_W-1:0] a);
        hits_ctrl = (a == ADDR_W'(`SCC_ADDR_CTRL));
    endfunction

    // ----------------------------------------
    // control register
    // ----------------------------------------
    scc_word_type ctrl_reg;
    scc_word_type ctrl_next;

    always_comb begin
        ctrl_next = ctrl_reg;
        if (reg_wr_i && hits_ctrl(reg_addr_i)) begin
            // bit fifteen is stored as written; keeping it zero is up to software
            ctrl_next = reg_wdata_i & `SCC_WRITE_MASK;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `SCC_RESET_CTRL;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i && hits_ctrl(reg_addr_i)) begin
            reg_rdata_o <= ctrl_reg;
        end else begin
            // unmapped reads and idle cycles return zero
            reg_rdata_o <= 16'h0000;
        end
    end

    // ----------------------------------------
    // analog controls
    // ----------------------------------------
    // every control output follows ctrl_next, so it moves on the edge
    // that stores the write instead of one clock after it
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            analog_regulator_off_o <= 1'b0;
        end else begin
            analog_regulator_off_o <= ctrl_next[`SCC_BIT_REG_OFF];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cal_range_double_o <= 1'b0;
        end else begin
            cal_range_double_o <= ctrl_next[`SCC_BIT_CAL_DOUBLE];
        end
    end

    // ----------------------------------------
    // standby keep-alive controls
    // ----------------------------------------
    // diagnostics stay alive in standby only while this is high
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            standby_diag_keepalive_o <= 1'b0;
        end else begin
            standby_diag_keepalive_o <= ctrl_next[`SCC_BIT_DIAG_KEEP];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            gpo_keepalive_o <= 1'b0;
        end else begin
            gpo_keepalive_o <= ctrl_next[`SCC_BIT_GPO_KEEP];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pwr_switch_keepalive_o <= 1'b0;
        end else begin
            pwr_switch_keepalive_o <= ctrl_next[`SCC_BIT_PWR_SWITCH_KEEP];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bias_keepalive_o <= 1'b0;
        end else begin
            bias_keepalive_o <= ctrl_next[`SCC_BIT_BIAS_KEEP];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            burnout_keepalive_o <= 1'b0;
        end else begin
            burnout_keepalive_o <= ctrl_next[`SCC_BIT_BURN_KEEP];
        end
    end

    // ----------------------------------------
    // oscillator keep-alive
    // ----------------------------------------
    // outside standby the oscillator is never released by this block
    // in standby it may stop unless the diagnostic keep-alive bit is set
    // and an enabled voltage check on the internal clock still needs it
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            osc_keepalive_o <= 1'b1;
        end else begin
            osc_keepalive_o <= !in_standby_i ||
                (ctrl_next[`SCC_BIT_DIAG_KEEP] && overunder_err_enabled_i && internal_clk_selected_i);
        end
    end

    // ----------------------------------------
    // output pin two
    // ----------------------------------------
    // routing takes the pin over; the general-purpose settings
    // have no effect until routing is cleared again
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            output_pin_two_oe_o <= 1'b0;
        end else if (ctrl_next[`SCC_BIT_ROUTE]) begin
            output_pin_two_oe_o <= 1'b1;
        end else begin
            output_pin_two_oe_o <= pin_two_output_enable_i;
        end
    end

    // the indicator is active low: low in standby, high while converting
    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            output_pin_two_o <= 1'b0;
        end else if (ctrl_next[`SCC_BIT_ROUTE]) begin
            output_pin_two_o <= !in_standby_i;
        end else begin
            output_pin_two_o <= pin_two_output_value_i;
        end
    end

endmodule

// ---- test/scc_chk.sv ----
/* checker on the control register ports; assumes scc_defs.svh is on the include path */
`timescale 1ns/1ns
`include "scc_defs.svh"
module scc_chk #(parameter int ADDR_W = 8) (
    input wire logic ref_clk_i, resetn_i, reg_wr_i, reg_rd_i, in_standby_i, pin_two_output_enable_i,
    input wire logic pin_two_output_value_i, overunder_err_enabled_i, internal_clk_selected_i,
    input wire logic analog_regulator_off_o, cal_range_double_o, standby_diag_keepalive_o,
    input wire logic osc_keepalive_o, output_pin_two_o, output_pin_two_oe_o,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i, reg_rdata_o
);
    logic [1:0] up_reg;
    logic [15:0] sh_reg;
    wire logic w = reg_wr_i && reg_addr_i == `SCC_ADDR_CTRL;
    wire logic on = up_reg == 2'h3;
    wire logic kp = standby_diag_keepalive_o && overunder_err_enabled_i && internal_clk_selected_i;
    // outputs only wake two flops after the pin reset lets go
    always_ff @(posedge ref_clk_i or negedge resetn_i)
        if (!resetn_i) up_reg <= 2'h0;
        else if (!on) up_reg <= up_reg + 2'h1;
    always_ff @(posedge ref_clk_i or negedge resetn_i)
        if (!resetn_i) sh_reg <= `SCC_RESET_CTRL;
        else if (w) sh_reg <= reg_wdata_i & `SCC_WRITE_MASK;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_ro; on && w |=> analog_regulator_off_o == $past(reg_wdata_i[4]); endproperty
    a_ro: assert property (p_ro) else $error("regulator off wrong");
    property p_cd; on && w |=> cal_range_double_o == $past(reg_wdata_i[13]); endproperty
    a_cd: assert property (p_cd) else $error("cal double wrong");
    property p_dk; on && w |=> standby_diag_keepalive_o == $past(reg_wdata_i[7]); endproperty
    a_dk: assert property (p_dk) else $error("diag keep wrong");
    // both timings of the routing bit are accepted, so only settled stretches are judged
    property p_rt; on && sh_reg[8] && $past(sh_reg[8]) |->
        output_pin_two_oe_o && output_pin_two_o == !$past(in_standby_i); endproperty
    a_rt: assert property (p_rt) else $error("routed pin wrong");
    property p_gp; on && !sh_reg[8] && !$past(sh_reg[8]) |-> output_pin_two_oe_o ==
        $past(pin_two_output_enable_i) && output_pin_two_o == $past(pin_two_output_value_i); endproperty
    a_gp: assert property (p_gp) else $error("plain pin wrong");
    property p_ok; on && $stable(standby_diag_keepalive_o) |->
        osc_keepalive_o == (!$past(in_standby_i) || $past(kp)); endproperty
    a_ok: assert property (p_ok) else $error("osc keep wrong");
    property p_rd; on && reg_rd_i |=>
        reg_rdata_o == ($past(reg_addr_i) == `SCC_ADDR_CTRL ? $past(sh_reg) : 16'h0000); endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    property p_id; on && !reg_rd_i |=> reg_rdata_o == 16'h0000; endproperty
    a_id: assert property (p_id) else $error("idle read data");
endmodule
bind scc_standby_cal_ctrl scc_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ---- test/tb_top.sv ----
/* bench: random writes, reads and pin states; assumes the checker is bound */
`timescale 1ns/1ns
`include "scc_defs.svh"
module tb_top import scc_pkg::*; ;
    logic ref_clk_i = 0, resetn_i = 0, wr = 0, rd = 0, rv = 0, sb = 0, en = 0, va = 0, ou = 0, ic = 0;
    logic ro, cd, dk, gk, pk, bk, uk, ok, p2, oe;
    scc_addr_type ad = 0;
    scc_word_type wd = 0, rs, d = 0, lf = 16'h0041, q[$];
    int n_errors = 0, total_checks = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    scc_standby_cal_ctrl dut (.ref_clk_i, .resetn_i, .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rs), .in_standby_i(sb), .pin_two_output_enable_i(en),
        .pin_two_output_value_i(va), .overunder_err_enabled_i(ou), .internal_clk_selected_i(ic),
        .analog_regulator_off_o(ro), .cal_range_double_o(cd), .standby_diag_keepalive_o(dk),
        .gpo_keepalive_o(gk), .pwr_switch_keepalive_o(pk), .bias_keepalive_o(bk), .burnout_keepalive_o(uk),
        .osc_keepalive_o(ok), .output_pin_two_o(p2), .output_pin_two_oe_o(oe));
    function automatic scc_word_type lfsr_next(scc_word_type v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(string n, scc_word_type e, scc_word_type s);
        total_checks++;
        if (s !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(logic w, scc_addr_type a, scc_word_type v);
        @(posedge ref_clk_i);
        {ad, wd, wr, rd} <= {a, v, w, !w};
        if (!w) q.push_back(a == `SCC_ADDR_CTRL ? d : 16'h0000);
        @(posedge ref_clk_i);
        {wr, rd} <= 2'h0;
    endtask
    always @(posedge ref_clk_i) begin
        rv <= rd;
        if (rv) chk("rdata", q.pop_front(), rs);
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200_000;
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        resetn_i <= 1;
        repeat (2) @(posedge ref_clk_i);
        acc(0, 8'h39, 0);
        acc(1, 8'h39, 16'h2000);
        d = 16'h2000;
        acc(0, 8'h39, 0);
        #1;
        chk("cal_double", 16'h0001, cd);
        repeat (40) begin
            lf = lfsr_next(lf);
            acc(1, 8'h39, lf & 16'h7fff);
            d = lf & 16'h7fff & `SCC_WRITE_MASK;
            {sb, en, va, ou, ic} <= {lf[14], lf[12:11], lf[9], lf[2]};
            acc(1, 8'h3a, 16'hffff);
            acc(0, 8'h39, 0);
            acc(0, 8'h3a, 0);
            #1;
            chk("reg_off", d[4], ro);
            chk("pin_oe", d[8] | en, oe);
            chk("pin_level", d[8] ? !sb : va, p2);
            chk("osc_keep", !sb | d[7] & ou & ic, ok);
            chk("cal_double", d[13], cd);
            chk("diag_keep", d[7], dk);
            chk("keep_bits", {d[6], d[5], d[3], d[1]}, {gk, pk, bk, uk});
        end
        // second reset in mid-run: register must come back cleared
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 0;
        #1;
        chk("osc_in_reset", 16'h0001, ok);
        chk("reg_off_in_reset", 16'h0000, ro);
        repeat (5) @(posedge ref_clk_i);
        resetn_i <= 1;
        d = 0;
        repeat (2) @(posedge ref_clk_i);
        acc(0, 8'h39, 0);
        repeat (2) @(posedge ref_clk_i);
        chk("pending", 16'h0000, 16'(q.size()));
        end_of_test();
    end
endmodule
